// >>> hdl/xlate_pkg.sv
// Constants for the address translation cache and transparent windows.
// Assumes one clock and a 32-bit APB register port.
// Notes on behaviour
// (RULE_01) Cache holds 64 translations, four-way set associative, tag, status, address, attributes.
// (RULE_02) Two-bit policy: 00 write-through, 01 copyback, 10 serialized, 11 noncachable.
// (RULE_03) Stored privilege bit is one for supervisor entries and joins tag compare.
// (RULE_04) Global entries survive the local purge variants.
// (RULE_05) Tag covers bits 31..12 for 4K pages, 31..13 for 8K pages.
// (RULE_06) Write hitting entry with modified clear walks, reloads entry, then retries.
// (RULE_07) Resident bit set only when walk saw no nonresident page or error.
// (RULE_08) Supervisor-only entries refuse user accesses.
// (RULE_09) User attribute bits go out only during an external bus transfer; the outputs are registered and follow bus_xfer one cycle late.
// (RULE_10) Valid set on load, cleared by a matching purge or purge-all.
// (RULE_11) Write-protected entry aborts writes and read-modify-writes at once.
// (RULE_12) Set index is four bits above page offset; valid tag and privilege match hits.
// (RULE_13) Miss aborts the access, walks tables, stores the translation, signals retry.
// (RULE_14) 4K: bit 12 indexes, bit 16 compared; 8K: bit 16 indexes, bit 12 passes.
// (RULE_15) Software disables translation before page size change and purges before enabling.
// (RULE_16) Lookup overlaps the cache indexing cycle; a hit costs no extra cycle.
// (RULE_17) Fill an invalid way first, else the way named by the access counter.
// (RULE_18) Two windows, each disableable, each covering at least 16 Mbytes.
// (RULE_19) Window matches on privilege field and top eight bits, masked bits excluded.
// (RULE_20) Write-protected matching window aborts writes and read-modify-writes.
// (RULE_21) Window match passes the address through; first window wins when both match.
// (RULE_22) Windows are checked before the cache and override a cache hit.
// (RULE_23) Hit on an entry made by a failed walk aborts with bus error.
// (RULE_24) Replacement counter wraps modulo four and picks the way directly.

package xlate_pkg;
	// Register byte offsets
	localparam logic [11:0] OFS_CTRL    = 12'h000;
	localparam logic [11:0] OFS_WIN0    = 12'h004;
	localparam logic [11:0] OFS_WIN1    = 12'h008;
	localparam logic [11:0] OFS_PADDR   = 12'h00C;
	localparam logic [11:0] OFS_PCMD    = 12'h010;
	localparam logic [11:0] OFS_STATUS  = 12'h014;

	// Control register bits
	localparam int CTRL_EN      = 0;
	localparam int CTRL_PAGE8K  = 1;

	// Window register fields
	localparam int WIN_BASE     = 24;
	localparam int WIN_MASK     = 16;
	localparam int WIN_EN       = 15;
	localparam int WIN_SBOTH    = 14;
	localparam int WIN_SSUP     = 13;
	localparam int WIN_U1       = 9;
	localparam int WIN_U0       = 8;
	localparam int WIN_POL      = 5;
	localparam int WIN_WP       = 2;

	// Purge address register: bit 0 is the privilege of the purged entry
	localparam int PADDR_SUP    = 0;

	// Purge operations
	typedef enum logic [1:0] {
		PURGE_ONE       = 2'b00,
		PURGE_ALL       = 2'b01,
		PURGE_LOCAL     = 2'b10,
		PURGE_ALL_LOCAL = 2'b11
	} purge_op_t;

	// Caching policy codes
	localparam logic [1:0] POL_WTHRU    = 2'h0;
	localparam logic [1:0] POL_COPYBACK = 2'h1;
	localparam logic [1:0] POL_SERIAL   = 2'h2;
	localparam logic [1:0] POL_NOCACHE  = 2'h3;

	// Cache geometry
	localparam int ENTRIES      = 64;
	localparam int WAYS         = 4;
	localparam int SETS         = 16;

	// Entry layout
	localparam int E_TAG        = 0;
	localparam int E_PA         = 20;
	localparam int E_POL        = 40;
	localparam int E_U0         = 42;
	localparam int E_U1         = 43;
	localparam int E_S          = 44;
	localparam int E_W          = 45;
	localparam int E_M          = 46;
	localparam int E_R          = 47;
	localparam int E_PRIV       = 48;
	localparam int E_WIDTH      = 49;

	// Reset values
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	localparam logic [31:0] WIN_RST  = 32'h0000_0000;
endpackage : xlate_pkg

// >>> hdl/way_store.sv
// Entry storage: one word per entry, all ways of a set read together.
// Assumes the caller keeps valid and global bits in flip-flops of its own.
`timescale 1ns/1ps

module way_store #(
	parameter int SETS  = 16,
	parameter int WAYS  = 4,
	parameter int WIDTH = 49
) (
	// Clock
	input  wire logic                    clk,
	// Read port, data one cycle later
	input  wire logic                    rd_en,
	input  wire logic [$clog2(SETS)-1:0] rd_idx,
	output logic      [WAYS*WIDTH-1:0]   rd_data,
	// Write port
	input  wire logic                    wr_en,
	input  wire logic [$clog2(SETS)-1:0] wr_idx,
	input  wire logic [$clog2(WAYS)-1:0] wr_way,
	input  wire logic [WIDTH-1:0]        wr_data
);
	logic [WIDTH-1:0] mem [SETS*WAYS];

	initial
	begin
		if (SETS < 2 || WAYS < 2)
			$error("way_store needs at least two sets and two ways");
	end

	always_ff @(posedge clk)
	begin
		if (wr_en)
			mem[{wr_idx, wr_way}] <= wr_data;
	end

	always_ff @(posedge clk)
	begin
		if (rd_en)
			for (int w = 0; w < WAYS; w++)
				rd_data[w*WIDTH +: WIDTH] <= mem[{rd_idx, w[$clog2(WAYS)-1:0]}];
	end
endmodule : way_store

// >>> hdl/xlate_cache.sv
// Address translation for one memory unit: 64-entry cache plus two windows.
// Assumes one access in flight, a table walker that answers with walk_done,
// and a cache controller that flags external transfers on bus_xfer.
//
// Local design decisions: the APB register port and the register addresses.
`timescale 1ns/1ps

module xlate_cache
	import xlate_pkg::*;
(
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Access request from the execution unit
	input  wire logic        acc_valid,
	output logic             acc_ready,
	input  wire logic [31:0] acc_addr,
	input  wire logic        acc_write,
	input  wire logic        acc_rmw,
	input  wire logic        acc_super,
	// Translation result
	output logic             res_valid,
	output logic             res_ok,
	output logic             res_abort,
	output logic             res_acc_err,
	output logic             res_bus_err,
	output logic      [31:0] res_paddr,
	output logic      [1:0]  caching_policy,
	output logic             retry,
	// User attributes to the bus
	input  wire logic        bus_xfer,
	output logic             user_attr_out_zero,
	output logic             user_attr_out_one,
	// Table walker
	output logic             walk_req,
	output logic      [31:0] walk_addr,
	output logic             walk_super,
	output logic             walk_write,
	input  wire logic        walk_done,
	input  wire logic [19:0] walk_pa,
	input  wire logic [1:0]  walk_policy,
	input  wire logic        walk_u0,
	input  wire logic        walk_u1,
	input  wire logic        walk_s,
	input  wire logic        walk_w,
	input  wire logic        walk_m,
	input  wire logic        walk_global,
	input  wire logic        walk_nonres,
	input  wire logic        walk_tea
);
	import xlate_pkg::*;

	typedef enum logic [2:0] {S_IDLE, S_LOOK, S_WALK, S_FILL, S_PSCAN} state_t;

	// Set index, four bits above the page offset
	function automatic logic [3:0] set_index(input logic [31:0] la, input logic p8k);
		return p8k ? la[16:13] : la[15:12];
	endfunction : set_index

	// Tag and privilege compare
	function automatic logic tag_hit(input logic [E_WIDTH-1:0] e, input logic [31:0] la,
	                                 input logic sup, input logic p8k);
		return (e[E_PRIV] == sup) &&
		       (p8k ? (e[E_TAG+5 +: 15] == la[31:17]) : (e[E_TAG+4 +: 16] == la[31:16]));
	endfunction : tag_hit

	// (RULE_19) match on privilege and top byte
	function automatic logic win_hit(input logic [31:0] w, input logic [31:0] la,
	                                 input logic sup);
		return w[WIN_EN] &&
		       (((w[WIN_BASE +: 8] ^ la[31:24]) & ~w[WIN_MASK +: 8]) == 8'h00) &&
		       (w[WIN_SBOTH] || (w[WIN_SSUP] == sup));
	endfunction : win_hit

	state_t                      state_r;
	logic   [31:0]               ctrl_r;
	logic   [31:0]               win0_r;
	logic   [31:0]               win1_r;
	logic   [31:0]               purge_addr_r;
	logic   [1:0]                purge_op_r;
	logic                        purge_pend_r;
	logic                        purge_take;
	logic   [ENTRIES-1:0]        valid_r;
	logic   [ENTRIES-1:0]        global_r;
	logic   [1:0]                repl_r;
	logic   [31:0]               la_r;
	logic                        wr_r;
	logic                        sup_r;
	logic   [3:0]                idx_r;
	logic   [1:0]                fill_way_r;
	logic                        attr_u0_r;
	logic                        attr_u1_r;
	logic   [E_WIDTH-1:0]        fill_r;
	logic                        fill_glb_r;
	logic   [WAYS*E_WIDTH-1:0]   set_data;
	logic                        rd_en;
	logic   [3:0]                rd_idx;
	logic                        accept;
	logic                        p8k;
	logic                        w0_hit;
	logic                        w1_hit;
	logic   [WAYS-1:0]           hit_vec;
	logic   [WAYS-1:0]           inv_vec;
	logic   [1:0]                hit_way;
	logic   [1:0]                inv_way;
	logic   [E_WIDTH-1:0]        hit_e;
	logic                        apb_wr;
	logic                        apb_setup;

	assign p8k       = ctrl_r[CTRL_PAGE8K];
	assign accept    = (state_r == S_IDLE) && acc_valid && acc_ready;
	assign apb_setup = psel && !penable;
	assign apb_wr    = psel && penable && pready && pwrite;

	// An access goes before a pending purge
	assign purge_take = (state_r == S_IDLE) && purge_pend_r && !accept;

	// (RULE_16) lookup in parallel
	assign rd_en  = accept || purge_take;
	assign rd_idx = accept ? set_index(acc_addr, p8k) : set_index(purge_addr_r, p8k);

	// (RULE_01) 64 entries, four ways
	way_store #(
		.SETS  (SETS),
		.WAYS  (WAYS),
		.WIDTH (E_WIDTH)
	) u_store (
		.clk     (pclk),
		.rd_en   (rd_en),
		.rd_idx  (rd_idx),
		.rd_data (set_data),
		.wr_en   (state_r == S_FILL),
		.wr_idx  (idx_r),
		.wr_way  (fill_way_r),
		.wr_data (fill_r)
	);

	// Hit and free-way search over the indexed set
	always_comb
	begin
		hit_vec = '0;
		inv_vec = '0;
		hit_way = 2'd0;
		inv_way = 2'd0;
		hit_e   = '0;
		for (int w = WAYS - 1; w >= 0; w--)
		begin
			// (RULE_12) valid tag hit
			// (RULE_03) privilege compare
			hit_vec[w] = valid_r[{idx_r, w[1:0]}] &&
			             tag_hit(set_data[w*E_WIDTH +: E_WIDTH], la_r, sup_r, p8k);
			inv_vec[w] = !valid_r[{idx_r, w[1:0]}];
			if (hit_vec[w])
			begin
				hit_way = w[1:0];
				hit_e   = set_data[w*E_WIDTH +: E_WIDTH];
			end
			if (inv_vec[w])
				inv_way = w[1:0];
		end
	end

	// (RULE_18) two windows, each with enable
	assign w0_hit = win_hit(win0_r, la_r, sup_r);
	assign w1_hit = win_hit(win1_r, la_r, sup_r);

	// APB register file, zero wait states
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl_r       <= CTRL_RST;
			win0_r       <= WIN_RST;
			win1_r       <= WIN_RST;
			purge_addr_r <= 32'h0000_0000;
			purge_op_r   <= PURGE_ONE;
			purge_pend_r <= 1'b0;
			pready       <= 1'b0;
			pslverr      <= 1'b0;
			prdata       <= 32'h0000_0000;
		end
		else
		begin
			pready  <= apb_setup;
			pslverr <= 1'b0;
			if (purge_take)
				purge_pend_r <= 1'b0;
			if (apb_setup)
			begin
				prdata <= 32'h0000_0000;
				unique case (paddr)
					OFS_CTRL:   prdata <= {30'h0000_0000, ctrl_r[1:0]};
					OFS_WIN0:   prdata <= win0_r;
					OFS_WIN1:   prdata <= win1_r;
					OFS_PADDR:  prdata <= purge_addr_r;
					OFS_PCMD:   prdata <= {30'h0000_0000, purge_op_r};
					OFS_STATUS: prdata <= {28'h000_0000, repl_r, purge_pend_r,
					                       state_r != S_IDLE};
					default:    pslverr <= 1'b1;
				endcase
			end
			if (apb_wr)
			begin
				unique case (paddr)
					OFS_CTRL:  ctrl_r <= {30'h0000_0000, pwdata[1:0]};
					OFS_WIN0:  win0_r <= pwdata;
					OFS_WIN1:  win1_r <= pwdata;
					OFS_PADDR: purge_addr_r <= pwdata;
					OFS_PCMD:
					begin
						// A command while one is pending is dropped
						if (!purge_pend_r)
						begin
							purge_op_r   <= pwdata[1:0];
							purge_pend_r <= 1'b1;
						end
					end
					default: ;
				endcase
			end
		end
	end

	// Replacement pointer, one step per access
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			repl_r <= 2'd0;
		else if (accept)
			// (RULE_24) wraps modulo four
			repl_r <= repl_r + 2'd1;
	end

	// Valid and global bits
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			valid_r  <= '0;
			global_r <= '0;
		end
		else if (state_r == S_FILL)
		begin
			// (RULE_10) valid on load
			valid_r[{idx_r, fill_way_r}]  <= 1'b1;
			global_r[{idx_r, fill_way_r}] <= fill_glb_r;
		end
		else if (purge_take && purge_op_r[0])
		begin
			// (RULE_04) global survives local purge
			for (int i = 0; i < ENTRIES; i++)
				if (!(purge_op_r[1] && global_r[i]))
					valid_r[i] <= 1'b0;
		end
		else if (state_r == S_PSCAN)
		begin
			// (RULE_10) purge clears matching entries
			for (int w = 0; w < WAYS; w++)
				if (tag_hit(set_data[w*E_WIDTH +: E_WIDTH], la_r, sup_r, p8k) &&
				    !(purge_op_r[1] && global_r[{idx_r, w[1:0]}]))
					valid_r[{idx_r, w[1:0]}] <= 1'b0;
		end
	end

	// Access sequencer and result outputs
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_r        <= S_IDLE;
			acc_ready      <= 1'b0;
			la_r           <= 32'h0000_0000;
			wr_r           <= 1'b0;
			sup_r          <= 1'b0;
			idx_r          <= 4'h0;
			fill_way_r     <= 2'd0;
			fill_r         <= '0;
			fill_glb_r     <= 1'b0;
			res_valid      <= 1'b0;
			res_ok         <= 1'b0;
			res_abort      <= 1'b0;
			res_acc_err    <= 1'b0;
			res_bus_err    <= 1'b0;
			res_paddr      <= 32'h0000_0000;
			caching_policy <= POL_WTHRU;
			attr_u0_r      <= 1'b0;
			attr_u1_r      <= 1'b0;
			retry          <= 1'b0;
			walk_req       <= 1'b0;
			walk_addr      <= 32'h0000_0000;
			walk_super     <= 1'b0;
			walk_write     <= 1'b0;
		end
		else
		begin
			res_valid   <= 1'b0;
			res_ok      <= 1'b0;
			res_abort   <= 1'b0;
			res_acc_err <= 1'b0;
			res_bus_err <= 1'b0;
			retry       <= 1'b0;
			unique case (state_r)
				S_IDLE:
				begin
					acc_ready <= !accept && !purge_take;
					if (accept)
					begin
						la_r    <= acc_addr;
						wr_r    <= acc_write || acc_rmw;
						sup_r   <= acc_super;
						idx_r   <= rd_idx;
						state_r <= S_LOOK;
					end
					else if (purge_take && !purge_op_r[0])
					begin
						la_r    <= purge_addr_r;
						sup_r   <= purge_addr_r[PADDR_SUP];
						idx_r   <= rd_idx;
						state_r <= S_PSCAN;
					end
				end
				S_LOOK:
				begin
					res_valid      <= 1'b1;
					res_paddr      <= la_r;
					caching_policy <= POL_WTHRU;
					attr_u0_r      <= 1'b0;
					attr_u1_r      <= 1'b0;
					state_r        <= S_IDLE;
					acc_ready      <= 1'b1;
					// (RULE_22) windows before cache
					if (w0_hit || w1_hit)
					begin
						// (RULE_21) first window wins
						caching_policy <= w0_hit ? win0_r[WIN_POL +: 2] : win1_r[WIN_POL +: 2];
						attr_u0_r      <= w0_hit ? win0_r[WIN_U0] : win1_r[WIN_U0];
						attr_u1_r      <= w0_hit ? win0_r[WIN_U1] : win1_r[WIN_U1];
						// (RULE_20) window write protect
						if (wr_r && (w0_hit ? win0_r[WIN_WP] : win1_r[WIN_WP]))
							res_acc_err <= 1'b1;
						else
							res_ok <= 1'b1;
					end
					else if (!ctrl_r[CTRL_EN])
						res_ok <= 1'b1;
					else if (hit_vec != '0)
					begin
						// (RULE_14) bit 12 from entry or address
						res_paddr <= {hit_e[E_PA+1 +: 19], p8k ? la_r[12] : hit_e[E_PA],
						              la_r[11:0]};
						// (RULE_02) policy from entry
						caching_policy <= hit_e[E_POL +: 2];
						attr_u0_r      <= hit_e[E_U0];
						attr_u1_r      <= hit_e[E_U1];
						// (RULE_23) failed walk entry
						if (!hit_e[E_R])
							res_bus_err <= 1'b1;
						// (RULE_08) supervisor only
						else if (hit_e[E_S] && !sup_r)
							res_acc_err <= 1'b1;
						// (RULE_11) write protect abort
						else if (wr_r && hit_e[E_W])
							res_acc_err <= 1'b1;
						// (RULE_06) first write walks
						else if (wr_r && !hit_e[E_M])
						begin
							res_abort  <= 1'b1;
							fill_way_r <= hit_way;
							walk_req   <= 1'b1;
							state_r    <= S_WALK;
							acc_ready  <= 1'b0;
						end
						else
							res_ok <= 1'b1;
					end
					else
					begin
						// (RULE_13) miss aborts and walks
						res_abort <= 1'b1;
						// (RULE_17) invalid way first
						fill_way_r <= (inv_vec != '0) ? inv_way : repl_r;
						walk_req   <= 1'b1;
						state_r    <= S_WALK;
						acc_ready  <= 1'b0;
					end
					walk_addr  <= la_r;
					walk_super <= sup_r;
					walk_write <= wr_r;
				end
				S_WALK:
				begin
					if (walk_done)
					begin
						walk_req <= 1'b0;
						// (RULE_05) tag keeps bits 31..12
						fill_r[E_TAG +: 20] <= la_r[31:12];
						fill_r[E_PA +: 20]  <= walk_pa;
						fill_r[E_POL +: 2]  <= walk_policy;
						fill_r[E_U0]        <= walk_u0;
						fill_r[E_U1]        <= walk_u1;
						fill_r[E_S]         <= walk_s;
						fill_r[E_W]         <= walk_w;
						fill_r[E_M]         <= walk_m;
						// (RULE_07) resident only on clean walk
						fill_r[E_R]         <= !(walk_nonres || walk_tea);
						fill_r[E_PRIV]      <= sup_r;
						fill_glb_r          <= walk_global;
						state_r             <= S_FILL;
					end
				end
				S_FILL:
				begin
					// Retry only once the entry is in place
					retry     <= 1'b1;
					acc_ready <= 1'b1;
					state_r   <= S_IDLE;
				end
				S_PSCAN:
				begin
					acc_ready <= 1'b1;
					state_r   <= S_IDLE;
				end
			endcase
		end
	end

	// User attributes shown the cycle after bus_xfer is high, and only then
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			user_attr_out_zero <= 1'b0;
			user_attr_out_one  <= 1'b0;
		end
		else
		begin
			// (RULE_09) attributes echo on bus
			user_attr_out_zero <= bus_xfer && attr_u0_r;
			user_attr_out_one  <= bus_xfer && attr_u1_r;
		end
	end
endmodule : xlate_cache

// >>> test/xlate_cache_assertions.sv
// Checker for the translation block.
// Sees only the ports of xlate_cache.
`timescale 1ns/1ps

module xlate_cache_assertions (
	// Clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// Access side
	input wire logic        acc_valid,
	input wire logic        acc_ready,
	input wire logic [31:0] acc_addr,
	input wire logic        res_valid,
	input wire logic        res_ok,
	input wire logic        res_abort,
	input wire logic        res_acc_err,
	input wire logic        res_bus_err,
	input wire logic        retry,
	// Bus attributes
	input wire logic        bus_xfer,
	input wire logic        user_attr_out_zero,
	input wire logic        user_attr_out_one,
	// Walker
	input wire logic        walk_req,
	input wire logic [31:0] walk_addr,
	input wire logic        walk_done
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	AST_RES_TWO: assert property (acc_valid && acc_ready |-> ##2 res_valid)
		else $error("late result");
	AST_LOOKUP_GAP: assert property (acc_valid && acc_ready |=> !res_valid && !acc_ready)
		else $error("busy lookup");
	AST_ONE_HOT: assert property (res_valid |->
		$onehot({res_ok, res_abort, res_acc_err, res_bus_err}))
		else $error("flags not one-hot");
	AST_MISS_WALK: assert property (res_valid && res_abort |->
		walk_req && walk_addr == $past(acc_addr, 2))
		else $error("abort without walk");
	AST_WALK_HOLD: assert property (walk_req && !walk_done |=> walk_req && $stable(walk_addr))
		else $error("walk request moved");
	AST_RETRY_TWO: assert property (walk_req && walk_done |-> ##2 retry && acc_ready)
		else $error("late retry");
	AST_NO_WALK: assert property (res_valid && !res_abort |=> !walk_req)
		else $error("stray walk");
	AST_ATTR_GATE: assert property (!bus_xfer |=> !user_attr_out_zero && !user_attr_out_one)
		else $error("stray attributes");
endmodule : xlate_cache_assertions

bind xlate_cache xlate_cache_assertions xlate_cache_assertions_i (.*);

// >>> test/walker_model.sv
// Table walker stand-in: answers each walk after a bench-set latency.
// Assumes walk_req stays up until the edge that takes walk_done.
`timescale 1ns/1ps

module walker_model (
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// Walk request
	input  wire logic        walk_req,
	input  wire logic [31:0] walk_addr,
	input  wire logic        walk_write,
	// Bench control: descriptor bits and latency
	input  wire logic [8:0]  desc,
	input  wire logic [3:0]  lat,
	// Answer
	output logic             walk_done,
	output logic      [19:0] walk_pa,
	output logic      [9:0]  walk_attr
);
	logic [3:0]  cnt;
	logic [29:0] ans;

	assign ans = {~walk_addr[31:28], walk_addr[27:13], ~walk_addr[12], desc[8:3], walk_write,
		desc[2:0]};

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cnt <= 4'h0;
			walk_done <= 1'h0;
			{walk_pa, walk_attr} <= 30'h0;
		end
		else
		begin
			walk_done <= 1'h0;
			// Outside the answer the lines toggle, so stale data never looks valid
			{walk_pa, walk_attr} <= ~{walk_pa, walk_attr};
			cnt <= (walk_req && !walk_done) ? cnt + 4'h1 : 4'h0;
			if (walk_req && !walk_done && cnt == lat)
			begin
				walk_done <= 1'h1;
				{walk_pa, walk_attr} <= ans;
			end
		end
	end
endmodule : walker_model

// >>> test/xlate_cache_bench.sv
// Bench: access table, then hand-written cases.
// Bench is APB master and execution unit; walker_model answers walks.
`timescale 1ns/1ps

module xlate_cache_bench;
	import xlate_pkg::*;
	typedef struct packed {logic [31:0] a; logic [1:0] w; logic s; logic [8:0] d; logic [1:0] c;} row_t;
	localparam logic [1:0]  C_OK = 2'h0, C_AB = 2'h1, C_AE = 2'h2, C_BE = 2'h3;
	localparam logic [31:0] LA = 32'h1234_5000, LB = 32'h3456_7000, LC = 32'h0ABC_D000;
	localparam logic [31:0] LD = 32'h0ABC_E000, LE = 32'h0ABC_4000, LG = 32'h0ABC_F000;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err, tt, p8k;
	logic        acc_valid, acc_ready, acc_write, acc_rmw, acc_super, res_valid, res_ok;
	logic        res_abort, res_acc_err, res_bus_err, retry, bus_xfer, walk_req, walk_super;
	logic        user_attr_out_zero, user_attr_out_one, walk_write, walk_done;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, acc_addr, res_paddr, walk_addr, rd;
	logic [1:0]  caching_policy, tpol;
	logic [19:0] walk_pa;
	logic [9:0]  wat;
	logic [8:0]  desc;
	logic [3:0]  lat;
	int          mismatches, n_checks;
	row_t        rows [22] = '{
		'{LA, 2'h0, 1'h0, 9'h000, C_AB}, '{LA, 2'h0, 1'h0, 9'h000, C_OK},
		'{LA, 2'h1, 1'h0, 9'h000, C_AB}, '{LA, 2'h1, 1'h0, 9'h000, C_OK},
		'{LA, 2'h0, 1'h1, 9'h000, C_AB}, '{LA, 2'h0, 1'h1, 9'h000, C_OK},
		'{LB, 2'h0, 1'h0, 9'h010, C_AB}, '{LB, 2'h0, 1'h0, 9'h010, C_AE},
		'{LB, 2'h0, 1'h1, 9'h010, C_AB}, '{LB, 2'h0, 1'h1, 9'h010, C_OK},
		'{LC, 2'h2, 1'h1, 9'h008, C_AB}, '{LC, 2'h2, 1'h1, 9'h008, C_AE},
		'{LD, 2'h0, 1'h0, 9'h002, C_AB}, '{LD, 2'h0, 1'h0, 9'h002, C_BE},
		'{LE, 2'h0, 1'h0, 9'h001, C_AB}, '{LE, 2'h0, 1'h0, 9'h001, C_BE},
		'{32'h4000_8000, 2'h0, 1'h0, 9'h080, C_AB}, '{32'h4000_8000, 2'h0, 1'h0, 9'h080, C_OK},
		'{32'h4000_9000, 2'h0, 1'h0, 9'h100, C_AB}, '{32'h4000_9000, 2'h0, 1'h0, 9'h100, C_OK},
		'{32'h4000_A000, 2'h0, 1'h0, 9'h180, C_AB}, '{32'h4000_A000, 2'h0, 1'h0, 9'h180, C_OK}};

	xlate_cache xlate_cache_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .acc_valid, .acc_ready, .acc_addr, .acc_write, .acc_rmw,
		.acc_super, .res_valid, .res_ok, .res_abort, .res_acc_err, .res_bus_err, .res_paddr,
		.caching_policy, .retry, .bus_xfer, .user_attr_out_zero, .user_attr_out_one, .walk_req,
		.walk_addr, .walk_super, .walk_write, .walk_done, .walk_pa, .walk_policy(wat[9:8]),
		.walk_u0(wat[7]), .walk_u1(wat[6]), .walk_s(wat[5]), .walk_w(wat[4]), .walk_m(wat[3]),
		.walk_global(wat[2]), .walk_nonres(wat[1]), .walk_tea(wat[0]));
	walker_model walker_model_i (.pclk, .presetn, .walk_req, .walk_addr, .walk_write, .desc,
		.lat, .walk_done, .walk_pa, .walk_attr(wat));

	task automatic final_report();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : final_report

	task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", n, exp, seen);
		end
	endtask : chk

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do @(posedge pclk); while (pready !== 1'h1);
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask : apb

	// Expected: windows pass through, 8K keeps bit 12
	function automatic logic [31:0] xp(input logic [31:0] a);
		xp = tt ? a : {~a[31:28], a[27:13], p8k ? a[12] : ~a[12], a[11:0]};
	endfunction : xp

	task automatic run(input logic [31:0] a, input logic [1:0] w, input logic s,
		input logic [8:0] d, input logic [1:0] c);
		desc <= d;
		lat <= lat + 4'h5;
		acc_addr <= a;
		{acc_rmw, acc_write} <= w;
		acc_super <= s;
		acc_valid <= 1'h1;
		do @(posedge pclk); while (acc_ready !== 1'h1);
		acc_valid <= 1'h0;
		do @(posedge pclk); while (res_valid !== 1'h1);
		chk("result", 32'({res_ok, res_acc_err | res_bus_err, res_abort | res_bus_err}),
			32'({c == C_OK, c}));
		if (c == C_OK)
		begin
			chk("paddr", res_paddr, xp(a));
			chk("policy", 32'(caching_policy), 32'(tt ? tpol : d[8:7]));
		end
		if (res_abort === 1'h1)
			do @(posedge pclk); while (retry !== 1'h1);
	endtask : run

	task automatic pg(input purge_op_t op, input logic [31:0] a);
		apb(1'h1, OFS_PADDR, a);
		apb(1'h1, OFS_PCMD, 32'(op));
		// Purge starts before next access
		@(posedge pclk);
	endtask : pg

	initial
	begin
		pclk = 1'h0;
		forever #2 pclk = ~pclk;
	end

	initial
	begin
		repeat (20000) @(posedge pclk);
		mismatches++;
		final_report();
	end

	initial
	begin
		{presetn, psel, penable, pwrite, paddr, pwdata, acc_valid, acc_addr} = '0;
		{acc_write, acc_rmw, acc_super, bus_xfer, desc, lat, tt, p8k, tpol} = '0;
		repeat (12) @(posedge pclk);
		presetn <= 1'h1;
		apb(1'h0, OFS_WIN0, 32'h0);
		chk("window reset", rd, 32'h0);
		apb(1'h0, 12'h020, 32'h0);
		chk("unmapped", 32'({err, rd[30:0]}), 32'h8000_0000);
		apb(1'h1, OFS_CTRL, 32'h0000_0001);
		foreach (rows[i])
			run(rows[i].a, rows[i].w, rows[i].s, rows[i].d, rows[i].c);
		tt = 1'h1;
		tpol = 2'h3;
		apb(1'h1, OFS_WIN0, 32'h1200_C064);
		run(LA, 2'h0, 1'h1, 9'h000, C_OK);
		run(LA, 2'h1, 1'h1, 9'h000, C_AE);
		apb(1'h1, OFS_WIN1, 32'h1200_C000);
		run(LA, 2'h2, 1'h1, 9'h000, C_AE);
		apb(1'h1, OFS_WIN0, 32'h0);
		tpol = 2'h0;
		run(LA, 2'h1, 1'h1, 9'h000, C_OK);
		apb(1'h1, OFS_WIN0, 32'h00FF_C000);
		run(LB, 2'h0, 1'h0, 9'h010, C_OK);
		apb(1'h1, OFS_WIN0, 32'h0);
		apb(1'h1, OFS_WIN1, 32'h1200_A000);
		tt = 1'h0;
		run(LA, 2'h0, 1'h0, 9'h000, C_OK);
		apb(1'h1, OFS_WIN1, 32'h0);
		pg(PURGE_ONE, LA);
		run(LA, 2'h0, 1'h0, 9'h000, C_AB);
		run(LA, 2'h0, 1'h1, 9'h000, C_OK);
		run(LG, 2'h0, 1'h0, 9'h064, C_AB);
		run(LG, 2'h0, 1'h0, 9'h064, C_OK);
		bus_xfer <= 1'h1;
		repeat (2) @(posedge pclk);
		chk("user attrs", 32'({user_attr_out_zero, user_attr_out_one}), 32'h3);
		bus_xfer <= 1'h0;
		pg(PURGE_LOCAL, LG);
		run(LG, 2'h0, 1'h0, 9'h064, C_OK);
		pg(PURGE_ALL_LOCAL, 32'h0);
		run(LG, 2'h0, 1'h0, 9'h064, C_OK);
		run(LA, 2'h0, 1'h1, 9'h000, C_AB);
		pg(PURGE_ALL, 32'h0);
		run(LG, 2'h0, 1'h0, 9'h064, C_AB);
		for (int i = 0; i < 8; i++)
			run(32'h5000_0000 | (32'(i % 4) << 16), 2'h0, 1'h0, 9'h000, i < 4 ? C_AB : C_OK);
		// translation off around the page size change
		apb(1'h1, OFS_CTRL, 32'h0000_0002);
		pg(PURGE_ALL, 32'h0);
		apb(1'h1, OFS_CTRL, 32'h0000_0003);
		p8k = 1'h1;
		run(32'h6000_1000, 2'h0, 1'h0, 9'h000, C_AB);
		run(32'h6000_1000, 2'h0, 1'h0, 9'h000, C_OK);
		presetn <= 1'h0;
		@(posedge pclk);
		chk("reset outputs", 32'({acc_ready, pready, res_valid, walk_req}), 32'h0);
		presetn <= 1'h1;
		tt = 1'h1;
		run(LA, 2'h0, 1'h0, 9'h000, C_OK);
		tt = 1'h0;
		p8k = 1'h0;
		apb(1'h1, OFS_CTRL, 32'h0000_0001);
		run(LA, 2'h0, 1'h0, 9'h000, C_AB);
		final_report();
	end
endmodule : xlate_cache_bench
